// ### obc_pkg.sv
// option decoder package: offsets, field positions, reset values and counts
// assumes every user writes obc_pkg::name, nothing is imported
`default_nettype none

package obc_pkg;

	// ------------------------------------------------------------
	// option store layout (byte index inside the store)
	// ------------------------------------------------------------
	localparam logic [2:0] STORE_WATCHDOG = 3'h0; // watchdog option byte
	localparam logic [2:0] STORE_OSC = 3'h1; // oscillator settle option byte
	localparam logic [2:0] STORE_BROWNOUT = 3'h2; // brownout option byte
	localparam logic [2:0] STORE_BOOT_LO = 3'h3; // boot select word, low byte
	localparam logic [2:0] STORE_BOOT_HI = 3'h4; // boot select word, high byte
	localparam logic [2:0] STORE_LAST = 3'h4; // last byte fetched at reset

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FREE_AUTO_BIT = 0; // free watchdog starts by itself
	localparam int FREE_HALT_BIT = 1; // free watchdog frozen in halt
	localparam int WIN_AUTO_BIT = 2; // window watchdog enabled by itself
	localparam int WIN_HALT_BIT = 3; // window watchdog resets on halt entry
	localparam int FAST_CNT_LSB = 0; // fast oscillator settle code [1:0]
	localparam int SLOW_CNT_LSB = 2; // slow oscillator settle code [3:2]
	localparam int BOR_EN_BIT = 0; // brownout reset enable
	localparam int BROWNOUT_THRESHOLD_SEL_LSB = 1; // brownout threshold [3:1]

	// ------------------------------------------------------------
	// register offsets (word index on the register port)
	// ------------------------------------------------------------
	localparam logic [3:0] REG_WATCHDOG_OPT = 4'h0; // watchdog_option_byte
	localparam logic [3:0] REG_OSC_OPT = 4'h1; // oscillator_settle_option_byte
	localparam logic [3:0] REG_BROWNOUT_OPT = 4'h2; // brownout_option_byte
	localparam logic [3:0] REG_BOOT_WORD = 4'h3; // boot_select_option_word
	localparam logic [3:0] REG_SW_CTRL = 4'h4; // software watchdog starts
	localparam logic [3:0] REG_STATUS = 4'h5; // loader and oscillator state
	localparam logic [3:0] REG_PROG_ADDR = 4'h6; // option store program address
	localparam logic [3:0] REG_PROG_DATA = 4'h7; // option store program data (write)

	// control and status bits
	localparam int SW_FREE_START_BIT = 0; // software start of free watchdog
	localparam int SW_WIN_START_BIT = 1; // software enable of window watchdog
	localparam int ST_READY_BIT = 0; // options latched
	localparam int ST_FAST_BIT = 1; // fast oscillator settled
	localparam int ST_SLOW_BIT = 2; // slow oscillator settled

	// ------------------------------------------------------------
	// settle counts for codes 00, 01, 10, 11
	// ------------------------------------------------------------
	localparam logic [12:0] SETTLE_CODE0 = 13'h0001; // 1 cycle
	localparam logic [12:0] SETTLE_CODE1 = 13'h0010; // 16 cycles
	localparam logic [12:0] SETTLE_CODE2 = 13'h0200; // 512 cycles
	localparam logic [12:0] SETTLE_CODE3 = 13'h1000; // 4096 cycles

	// reset values
	localparam logic [7:0] OPT_BYTE_RESET = 8'h00; // before loading
	localparam logic [15:0] BOOT_WORD_RESET = 16'h0000; // before loading

	// loader states, gray along the path
	typedef enum logic [1:0] {
		OBC_ST_ADDR = 2'b00, // present a store index
		OBC_ST_CAPT = 2'b01, // store data valid, capture it
		OBC_ST_DONE = 2'b11 // options held until next reset
	} obc_state_e;

endpackage

`default_nettype wire

// ### obc_store.sv
// option store: small array of option bytes with registered read data
// assumes one clock; the array is not cleared by reset so that programmed
// options survive it and are fetched again by the loader
`default_nettype none

module obc_store #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH]; // kept across reset on purpose

	// write port, no reset: models the non-volatile cells
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read port, one cycle latency from rd_addr
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

`default_nettype wire

// ### obc_option_decode.sv
// option decoder: fetches option bytes at reset and drives watchdog,
// oscillator settle, brownout and boot selection controls
// assumes one clock, synchronous inputs, and that watchdog, oscillator and
// brownout logic stay in reset until options_ready is high
//
// How it works
// - free watchdog auto start when option bit set
// - free watchdog frozen in halt when bit set
// - window watchdog enabled by hardware when bit set
// - halt entry resets if bit set, else stops
// - fast oscillator waits 1/16/512/4096 cycles
// - slow oscillator uses same settle encoding
// - brownout reset on or off by bit
// - three-bit brownout threshold from bits three:one
// - boot word held for boot code check
`default_nettype none

module obc_option_decode #(
	parameter int STORE_DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// chip status
	input wire logic halt_mode,
	input wire logic fast_osc_on,
	input wire logic fast_osc_tick,
	input wire logic slow_osc_on,
	input wire logic slow_osc_tick,
	// decoded controls
	output logic options_ready,
	output logic free_watchdog_active,
	output logic free_watchdog_count_en,
	output logic window_watchdog_enable,
	output logic window_watchdog_count_en,
	output logic window_watchdog_reset_req,
	output logic fast_osc_ready,
	output logic slow_osc_ready,
	output logic brownout_enable,
	output logic [2:0] brownout_threshold_sel,
	output logic [15:0] boot_select_word
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------

	// settle code to cycle count, shared by both oscillators
	function automatic logic [12:0] settle_cycles(input logic [1:0] code);
		case (code)
			2'b00: settle_cycles = obc_pkg::SETTLE_CODE0;
			2'b01: settle_cycles = obc_pkg::SETTLE_CODE1;
			2'b10: settle_cycles = obc_pkg::SETTLE_CODE2;
			default: settle_cycles = obc_pkg::SETTLE_CODE3;
		endcase
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	obc_pkg::obc_state_e state_reg; // loader state
	logic [2:0] load_idx_reg; // store index being fetched
	logic [7:0] store_rdata; // registered store output
	logic [7:0] wd_opt_reg; // latched watchdog option byte
	logic [7:0] osc_opt_reg; // latched oscillator option byte
	logic [7:0] bor_opt_reg; // latched brownout option byte
	logic [15:0] boot_word_reg; // latched boot select word
	logic sw_free_start_reg; // software started the free watchdog
	logic sw_win_start_reg; // software enabled the window watchdog
	logic [2:0] prog_addr_reg; // store index for programming
	logic halt_prev_reg; // halt_mode one cycle ago
	logic prog_wr; // program strobe into the store
	logic loaded; // loader finished
	logic [1:0] osc_on; // per oscillator: running
	logic [1:0] osc_tick; // per oscillator: one cycle tick
	logic [1:0] osc_code [2]; // per oscillator: two-bit settle code
	logic [1:0] osc_ready_reg; // per oscillator: settled
	logic [12:0] osc_target [2]; // per oscillator: cycles to wait

	assign loaded = (state_reg == obc_pkg::OBC_ST_DONE);
	assign prog_wr = reg_wr && (reg_addr == obc_pkg::REG_PROG_DATA);

	// ------------------------------------------------------------
	// option store
	// ------------------------------------------------------------

	// loader reads through load_idx_reg, software programs through its own index
	obc_store #(
		.WIDTH(8),
		.DEPTH(STORE_DEPTH),
		.AW(3)
	) u_store (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.wr_en(prog_wr),
		.wr_addr(prog_addr_reg),
		.wr_data(reg_wdata[7:0]),
		.rd_addr(load_idx_reg),
		.rd_data(store_rdata)
	);

	// ------------------------------------------------------------
	// loader
	// ------------------------------------------------------------

	// fetch sequence
	// two cycles per byte because store data come one cycle after the index
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_reg <= obc_pkg::OBC_ST_ADDR;
			load_idx_reg <= 3'h0;
		end else begin
			case (state_reg)
				obc_pkg::OBC_ST_ADDR: begin
					// index stands for one cycle, data follow
					state_reg <= obc_pkg::OBC_ST_CAPT;
				end
				obc_pkg::OBC_ST_CAPT: begin
					if (load_idx_reg == obc_pkg::STORE_LAST) begin
						state_reg <= obc_pkg::OBC_ST_DONE;
					end else begin
						load_idx_reg <= load_idx_reg + 3'h1;
						state_reg <= obc_pkg::OBC_ST_ADDR;
					end
				end
				obc_pkg::OBC_ST_DONE: begin
					// stay here until the next reset
					state_reg <= obc_pkg::OBC_ST_DONE;
				end
				default: begin
					state_reg <= obc_pkg::OBC_ST_ADDR;
				end
			endcase
		end
	end

	// latch option bytes
	// only captured during the fetch, so later programming waits for a reset
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wd_opt_reg <= obc_pkg::OPT_BYTE_RESET;
			osc_opt_reg <= obc_pkg::OPT_BYTE_RESET;
			bor_opt_reg <= obc_pkg::OPT_BYTE_RESET;
			boot_word_reg <= obc_pkg::BOOT_WORD_RESET;
		end else if (state_reg == obc_pkg::OBC_ST_CAPT) begin
			case (load_idx_reg)
				obc_pkg::STORE_WATCHDOG: wd_opt_reg <= store_rdata;
				obc_pkg::STORE_OSC: osc_opt_reg <= store_rdata;
				obc_pkg::STORE_BROWNOUT: bor_opt_reg <= store_rdata;
				obc_pkg::STORE_BOOT_LO: boot_word_reg[7:0] <= store_rdata;
				obc_pkg::STORE_BOOT_HI: boot_word_reg[15:8] <= store_rdata;
				default: begin
					// unused store bytes are not fetched
				end
			endcase
		end
	end

	// ready flag, released one cycle after the last byte is latched
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			options_ready <= 1'b0;
		end else begin
			options_ready <= loaded;
		end
	end

	// ------------------------------------------------------------
	// software control registers
	// ------------------------------------------------------------

	// software starts are sticky: once set, a start bit is cleared only by reset
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sw_free_start_reg <= 1'b0;
			sw_win_start_reg <= 1'b0;
		end else if (reg_wr && reg_addr == obc_pkg::REG_SW_CTRL) begin
			sw_free_start_reg <= sw_free_start_reg | reg_wdata[obc_pkg::SW_FREE_START_BIT];
			sw_win_start_reg <= sw_win_start_reg | reg_wdata[obc_pkg::SW_WIN_START_BIT];
		end
	end

	// programming index for the option store
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prog_addr_reg <= 3'h0;
		end else if (reg_wr && reg_addr == obc_pkg::REG_PROG_ADDR) begin
			prog_addr_reg <= reg_wdata[2:0];
		end
	end

	// ------------------------------------------------------------
	// watchdog controls
	// ------------------------------------------------------------

	// halt history for entry detection
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			halt_prev_reg <= 1'b0;
		end else begin
			halt_prev_reg <= halt_mode;
		end
	end

	// watchdog outputs held inactive until options are latched
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !loaded) begin
			free_watchdog_active <= 1'b0;
			free_watchdog_count_en <= 1'b0;
			window_watchdog_enable <= 1'b0;
			window_watchdog_count_en <= 1'b0;
			window_watchdog_reset_req <= 1'b0;
		end else begin
			free_watchdog_active <= wd_opt_reg[obc_pkg::FREE_AUTO_BIT] | sw_free_start_reg;
			free_watchdog_count_en <= (wd_opt_reg[obc_pkg::FREE_AUTO_BIT] | sw_free_start_reg)
				& ~(halt_mode & wd_opt_reg[obc_pkg::FREE_HALT_BIT]);
			window_watchdog_enable <= wd_opt_reg[obc_pkg::WIN_AUTO_BIT] | sw_win_start_reg;
			window_watchdog_count_en <= (wd_opt_reg[obc_pkg::WIN_AUTO_BIT] | sw_win_start_reg)
				& ~halt_mode;
			window_watchdog_reset_req <= halt_mode & ~halt_prev_reg
				& wd_opt_reg[obc_pkg::WIN_HALT_BIT];
		end
	end

	// ------------------------------------------------------------
	// oscillator settle counters
	// ------------------------------------------------------------
	assign osc_on = {slow_osc_on, fast_osc_on};
	assign osc_tick = {slow_osc_tick, fast_osc_tick};
	assign osc_code[0] = osc_opt_reg[obc_pkg::FAST_CNT_LSB +: 2];
	assign osc_code[1] = osc_opt_reg[obc_pkg::SLOW_CNT_LSB +: 2];

	generate
		for (genvar g = 0; g < 2; g++) begin : g_osc
			logic [12:0] cnt_reg; // oscillator cycles seen since it started
			logic rdy_reg; // this oscillator has settled, one flop per loop
			assign osc_target[g] = settle_cycles(osc_code[g]);
			assign osc_ready_reg[g] = rdy_reg;

			// count oscillator cycles, shared form also used
			// a stopped oscillator drops ready and starts over
			always_ff @(posedge clk_sys) begin
				if (!reset_n || !loaded || !osc_on[g]) begin
					cnt_reg <= 13'h0000;
					rdy_reg <= 1'b0;
				end else if (osc_tick[g] && !rdy_reg) begin
					cnt_reg <= cnt_reg + 13'h0001;
					rdy_reg <= (cnt_reg + 13'h0001) == osc_target[g];
				end
			end
		end
	endgenerate

	assign fast_osc_ready = osc_ready_reg[0];
	assign slow_osc_ready = osc_ready_reg[1];

	// ------------------------------------------------------------
	// brownout and boot outputs
	// ------------------------------------------------------------

	// held off until the options are latched
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !loaded) begin
			brownout_enable <= 1'b0;
			brownout_threshold_sel <= 3'h0;
			boot_select_word <= obc_pkg::BOOT_WORD_RESET;
		end else begin
			brownout_enable <= bor_opt_reg[obc_pkg::BOR_EN_BIT];
			brownout_threshold_sel <= bor_opt_reg[obc_pkg::BROWNOUT_THRESHOLD_SEL_LSB +: 3];
			boot_select_word <= boot_word_reg;
		end
	end

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------

	// data stand in the cycle after the strobe only; unmapped reads give zero
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !reg_rd) begin
			reg_rdata <= 16'h0000;
		end else begin
			case (reg_addr)
				obc_pkg::REG_WATCHDOG_OPT: reg_rdata <= {8'h00, wd_opt_reg};
				obc_pkg::REG_OSC_OPT: reg_rdata <= {8'h00, osc_opt_reg};
				obc_pkg::REG_BROWNOUT_OPT: reg_rdata <= {8'h00, bor_opt_reg};
				obc_pkg::REG_BOOT_WORD: reg_rdata <= boot_word_reg;
				obc_pkg::REG_SW_CTRL: reg_rdata <= {14'h0000, sw_win_start_reg, sw_free_start_reg};
				obc_pkg::REG_STATUS: reg_rdata <= {13'h0000, osc_ready_reg, loaded};
				obc_pkg::REG_PROG_ADDR: reg_rdata <= {13'h0000, prog_addr_reg};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule

`default_nettype wire

// ### obc_decode_assertions.sv
// checker for the option decoder: timing relations seen on its ports
// assumes it is bound to obc_option_decode and runs on clk_sys alone
`default_nettype none

module obc_decode_assertions (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic halt_mode,
	input wire logic fast_osc_on,
	input wire logic fast_osc_tick,
	input wire logic options_ready,
	input wire logic free_watchdog_active,
	input wire logic free_watchdog_count_en,
	input wire logic window_watchdog_enable,
	input wire logic window_watchdog_count_en,
	input wire logic window_watchdog_reset_req,
	input wire logic fast_osc_ready,
	input wire logic brownout_enable,
	input wire logic [2:0] brownout_threshold_sel,
	input wire logic [15:0] boot_select_word
);
	// --------------------------------------------
	// one domain, so clock and reset are shared
	// --------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_ready_delay: assert property (
		$rose(reset_n) |-> !options_ready [*8] ##[1:5] options_ready)
		else $error("options_ready not raised in the loader window");
	a_ready_holds: assert property (
		options_ready |=> options_ready)
		else $error("options_ready dropped without reset");
	a_opts_stable: assert property (
		options_ready && $past(options_ready) |-> $stable(boot_select_word) && $stable(brownout_enable)
		&& $stable(brownout_threshold_sel))
		else $error("latched options changed before reset");
	a_dec_wait: assert property (
		!options_ready |-> !brownout_enable && !fast_osc_ready && boot_select_word == 16'h0000)
		else $error("decoded output live before options latched");
	a_free_gate: assert property (
		free_watchdog_count_en |-> free_watchdog_active)
		else $error("free watchdog counting while inactive");
	a_win_halt_stop: assert property (
		halt_mode && $past(halt_mode) |-> !window_watchdog_count_en)
		else $error("window watchdog counting in halt");
	a_win_gate: assert property (
		window_watchdog_count_en |-> window_watchdog_enable)
		else $error("window watchdog counting while disabled");
	a_halt_pulse: assert property (
		window_watchdog_reset_req |=> !window_watchdog_reset_req)
		else $error("halt reset request longer than one cycle");
	a_halt_cause: assert property (
		window_watchdog_reset_req |-> $past(halt_mode))
		else $error("halt reset request without halt");
	a_fast_tick: assert property (
		$rose(fast_osc_ready) |-> $past(fast_osc_tick) && $past(fast_osc_on))
		else $error("fast oscillator ready without a tick");
	a_fast_off: assert property (
		!fast_osc_on |=> !fast_osc_ready)
		else $error("fast oscillator ready while stopped");
	a_read_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside the answer cycle");
endmodule

`default_nettype wire

// ### tb_option_byte_config_decode.sv
// testbench for the option decoder: programs the option store, resets,
// checks decoded controls, halt behaviour, settle counts and registers
// assumes obc_option_decode and obc_decode_assertions are compiled first
`default_nettype none

module tb_option_byte_config_decode;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic halt_mode = 1'b0;
	logic fast_osc_on = 1'b0;
	logic fast_osc_tick = 1'b0;
	logic slow_osc_on = 1'b0;
	logic slow_osc_tick = 1'b0;
	logic [15:0] reg_rdata, boot_select_word;
	logic options_ready, free_watchdog_active, free_watchdog_count_en, window_watchdog_enable;
	logic window_watchdog_count_en, window_watchdog_reset_req, fast_osc_ready, slow_osc_ready;
	logic brownout_enable;
	logic [2:0] brownout_threshold_sel;
	int bad_count = 0; // mismatches seen
	int checks = 0; // comparisons made

	obc_option_decode #(.STORE_DEPTH(8)) dut_u (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .halt_mode, .fast_osc_on, .fast_osc_tick, .slow_osc_on, .slow_osc_tick, .options_ready,
		.free_watchdog_active, .free_watchdog_count_en, .window_watchdog_enable, .window_watchdog_count_en,
		.window_watchdog_reset_req, .fast_osc_ready, .slow_osc_ready, .brownout_enable,
		.brownout_threshold_sel, .boot_select_word);

	// free-running 250 MHz clock
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	// --------------------------------------------
	// shared tasks
	// --------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one-cycle write strobe, released on the next edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask
	// store bytes in order: watchdog, oscillator, brownout, boot low, boot high
	task automatic load(input logic [7:0] w, input logic [7:0] o, input logic [7:0] b, input logic [15:0] bw);
		logic [7:0] bytes [5];
		bytes = '{w, o, b, bw[7:0], bw[15:8]};
		for (int i = 0; i < 5; i++) begin
			wr(4'h6, 16'(i));
			wr(4'h7, {8'h00, bytes[i]});
		end
	endtask
	// reset for four cycles, then wait a bounded time for the loader
	task automatic restart;
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int i = 0; i < 20 && options_ready !== 1'b1; i++) @(posedge clk_sys);
		#1;
		chk("options_ready", {15'h0000, options_ready}, 16'h0001);
	endtask
	// n oscillator ticks, one every two system cycles
	task automatic ticks(input logic slow, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			if (slow) slow_osc_tick <= 1'b1;
			else fast_osc_tick <= 1'b1;
			@(posedge clk_sys);
			fast_osc_tick <= 1'b0;
			slow_osc_tick <= 1'b0;
		end
		#1;
	endtask
	// decoded bits: active, count, window enable, brownout, threshold
	task automatic chk_dec(input logic [6:0] exp, input logic [15:0] bw);
		chk("decoded", {9'h000, free_watchdog_active, free_watchdog_count_en, window_watchdog_enable,
			brownout_enable, brownout_threshold_sel}, {9'h000, exp});
		chk("boot word", boot_select_word, bw);
	endtask
	// hold halt five cycles, count reset request pulses in the first four
	task automatic halt_run(input logic [15:0] pulses, input logic free_cnt);
		int n;
		n = 0;
		@(posedge clk_sys);
		halt_mode <= 1'b1;
		repeat (4) begin
			@(posedge clk_sys);
			#1;
			if (window_watchdog_reset_req === 1'b1) n++;
		end
		chk("halt pulses", 16'(n), pulses);
		chk("free count in halt", {15'h0000, free_watchdog_count_en}, {15'h0000, free_cnt});
		chk("window count in halt", {15'h0000, window_watchdog_count_en}, 16'h0000);
		@(posedge clk_sys);
		halt_mode <= 1'b0;
	endtask

	// --------------------------------------------
	// scenarios
	// --------------------------------------------
	task automatic t_load_a;
		load(8'h0D, 8'h01, 8'h0B, 16'h3C96);
		restart();
		chk_dec(7'b1111101, 16'h3C96);
		chk("window count", {15'h0000, window_watchdog_count_en}, 16'h0001);
		rd(4'h0, 16'h000D, "watchdog byte");
		rd(4'h1, 16'h0001, "osc byte");
		rd(4'h2, 16'h000B, "brownout byte");
		rd(4'h3, 16'h3C96, "boot reg");
		wr(4'h3, 16'hFFFF);
		rd(4'h3, 16'h3C96, "boot reg after write");
		rd(4'h9, 16'h0000, "unmapped");
		halt_run(16'h0001, 1'b1);
		$display("test load_a done");
	endtask
	task automatic t_osc(input int nf, input int ns);
		fast_osc_on <= 1'b1;
		slow_osc_on <= 1'b1;
		ticks(1'b0, nf - 1);
		chk("fast early", {15'h0000, fast_osc_ready}, 16'h0000);
		ticks(1'b0, 1);
		chk("fast settled", {15'h0000, fast_osc_ready}, 16'h0001);
		ticks(1'b1, ns - 1);
		chk("slow early", {15'h0000, slow_osc_ready}, 16'h0000);
		ticks(1'b1, 1);
		chk("slow settled", {15'h0000, slow_osc_ready}, 16'h0001);
		rd(4'h5, 16'h0007, "status");
		// inputs change only at a rising edge
		@(posedge clk_sys);
		fast_osc_on <= 1'b0;
		slow_osc_on <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("fast stopped", {15'h0000, fast_osc_ready}, 16'h0000);
		chk("slow stopped", {15'h0000, slow_osc_ready}, 16'h0000);
		$display("test osc done");
	endtask
	task automatic t_latch_b;
		load(8'h02, 8'h0E, 8'h04, 16'h5AA5);
		#1;
		chk_dec(7'b1111101, 16'h3C96);
		restart();
		chk_dec(7'b0000010, 16'h5AA5);
		wr(4'h4, 16'h0003);
		repeat (2) @(posedge clk_sys);
		#1;
		chk_dec(7'b1110010, 16'h5AA5);
		halt_run(16'h0000, 1'b0);
		$display("test latch_b done");
	endtask

	// watchdog: the tests need about 10k cycles, allow two and a half times that span
	initial begin
		#100us;
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_load_a();
		t_osc(16, 1);
		t_latch_b();
		t_osc(512, 4096);
		complete_run();
	end
endmodule

bind obc_option_decode obc_decode_assertions chk_u (.clk_sys, .reset_n, .reg_rd, .reg_rdata, .halt_mode,
	.fast_osc_on, .fast_osc_tick, .options_ready, .free_watchdog_active, .free_watchdog_count_en,
	.window_watchdog_enable, .window_watchdog_count_en, .window_watchdog_reset_req, .fast_osc_ready,
	.brownout_enable, .brownout_threshold_sel, .boot_select_word);

`default_nettype wire
